// ===== design/lmsf_regs.svh
`ifndef LMSF_REGS_SVH
`define LMSF_REGS_SVH

// word width and offsets
`define LMSF_DATA_W          13
`define LMSF_ADDR_W          8
`define LMSF_OFS_GEN_STATUS  8'h10
`define LMSF_OFS_SER_STATUS  8'h11

// general status field positions
`define LMSF_GEN_OTP_CRC     10
`define LMSF_GEN_CFG_PEND    9
`define LMSF_GEN_RES_DEC     8
`define LMSF_GEN_EXT_CLK     7
`define LMSF_GEN_SER_ERR     6
`define LMSF_GEN_OPEN        4
`define LMSF_GEN_SHORT       3
`define LMSF_GEN_PUMP_LOW    2
`define LMSF_GEN_THERMAL_SHUTDOWN_FLAG     1
`define LMSF_GEN_THERMAL_WARNING_FLAG     0

// general bits that may pull the fault output
`define LMSF_GEN_FAULT_EN    13'h01df

// serial status fields, all w1c
`define LMSF_SER_WDOG        8
`define LMSF_SER_TIMEOUT     7
`define LMSF_SER_CRC         6
`define LMSF_SER_SYNC_PAR    5
`define LMSF_SER_PL_PAR      4
`define LMSF_SER_SYNC_STOP   3
`define LMSF_SER_PL_STOP     2
`define LMSF_SER_PL_START    1
`define LMSF_SER_LSB         1
`define LMSF_SER_FLAGS       8

// reset values
`define LMSF_GEN_RESET       13'h0000
`define LMSF_SER_RESET       13'h0000

// timing
`define LMSF_CLK_MHZ         25
`define LMSF_RX_GAP_BITS     16
`define LMSF_WDOG_UNIT_US    1000
`define LMSF_WDOG_UNIT_CYC   (`LMSF_WDOG_UNIT_US * `LMSF_CLK_MHZ)
`define LMSF_EXTCLK_MIN_KHZ  100
`define LMSF_EXTCLK_MAX_CYC  ((`LMSF_CLK_MHZ * 1000) / `LMSF_EXTCLK_MIN_KHZ)
`define LMSF_WDOG_SET_W      4

`endif

// ===== design/lmsf_pkg.sv
package lmsf_pkg;

  // register word as seen on the register port
  typedef logic [12:0] lmsf_word_t;

  // inter-frame gap watcher states
  typedef enum logic [1:0] {
    GAP_IDLE,
    GAP_ARMED,
    GAP_TRIPPED
  } lmsf_gap_state_t;

endpackage : lmsf_pkg

// ===== design/lmsf_w1c_flags.sv
// sticky flags: hardware sets, a written 1 clears
module lmsf_w1c_flags #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,      // system clock
  input  wire logic             sys_rst,  // async reset, active high
  input  wire logic [WIDTH-1:0] set_ev,   // one-cycle set events
  input  wire logic [WIDTH-1:0] clr_req,  // write-1 clear strobes
  output logic      [WIDTH-1:0] flags_r   // sticky flag state
);

  logic [WIDTH-1:0] flags_nxt;  // next flag value

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("lmsf_w1c_flags: WIDTH must be at least 1");
    end
  endgenerate

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    flags_nxt = (flags_r & ~clr_req) | set_ev;
  end

  // flag storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : lmsf_w1c_flags

// ===== design/lmsf_status_top.sv
// Behaviour
// - otp checksum mismatch sets bit 10, no fault
// - bit 9 high while configuration runs
// - bit 8 high until grade decode done
// - bit 7 flags slow external dimming clock
// - bit 6 is or of serial errors
// - bit 4 is or of open flags
// - bit 3 is or of short flags
// - bit 2 shows charge pump below threshold
// - thermal shutdown latched in bit 1
// - thermal warning latched in bit 0
// - receive idle past watchdog time sets bit 8
// - gap over 16 bits sets bit 7, failsafe
// - crc failure rejected, bit 6 set
// - sync frame parity error sets bit 5
// - payload parity error sets bit 4
// - sync frame stop error sets bit 3
// - payload stop error sets bit 2
// - payload start error sets bit 1
// - fault low on any unmasked faultable bit
`include "lmsf_regs.svh"

module lmsf_status_top #(
  parameter int WDOG_UNIT_CYC  = `LMSF_WDOG_UNIT_CYC,   // clocks per watchdog unit
  parameter int EXTCLK_MAX_CYC = `LMSF_EXTCLK_MAX_CYC,  // longest legal ext period
  parameter int RX_GAP_BITS    = `LMSF_RX_GAP_BITS,     // allowed idle bit periods
  parameter int NUM_SW         = 12                     // number of switches
) (
  input  wire logic                        clk,              // system clock, 25 MHz
  input  wire logic                        sys_rst,          // async reset, high
  // register port
  input  wire logic                        reg_wr_en,        // write strobe
  input  wire logic                        reg_rd_en,        // read strobe
  input  wire logic [`LMSF_ADDR_W-1:0]     reg_addr,         // register offset
  input  wire logic [`LMSF_DATA_W-1:0]     reg_wdata,        // write data
  output lmsf_pkg::lmsf_word_t             reg_rdata,        // read data
  output logic                             reg_rvalid,       // read data valid
  // general status sources
  input  wire logic                        otp_check_done,   // otp readback ended
  input  wire logic                        otp_crc_ok,       // readback matched
  input  wire logic                        cfg_start,        // config write taken
  input  wire logic                        cfg_done,         // config finished
  input  wire logic                        grade_read_done,  // resistor decode done
  input  wire logic [1:0]                  dim_clk_sel,      // dimming clock select
  input  wire logic                        ext_clock_input,  // external ref clock
  input  wire logic [NUM_SW-1:0]           per_switch_open_flags,   // open flags
  input  wire logic [NUM_SW-1:0]           per_switch_short_flags,  // short flags
  input  wire logic                        pump_voltage_low, // charge pump low
  input  wire logic                        thermal_shdn_ev,  // shutdown event
  input  wire logic                        thermal_warn_ev,  // warning event
  input  wire logic [8:0]                  gen_fault_mask,   // mask bits 8..0
  input  wire logic [NUM_SW-1:0]           led_fault_mask,   // per led mask
  // serial receive sources
  input  wire logic                        rx_pin,           // receive line
  input  wire logic                        bit_tick,         // one per bit period
  input  wire logic                        frame_active,     // frame in progress
  input  wire logic [`LMSF_WDOG_SET_W-1:0] idle_timeout_setting, // 0 = off
  input  wire logic                        rx_crc_fail,      // crc check failed
  input  wire logic                        rx_sync_par_err,  // sync parity error
  input  wire logic                        rx_pl_par_err,    // payload parity error
  input  wire logic                        rx_sync_stop_err, // sync stop error
  input  wire logic                        payload_stopbit_fail,   // payload stop error
  input  wire logic                        payload_startbit_fail,  // payload start error
  // outputs
  output logic                             frame_reject,     // drop current frame
  output logic                             failsafe_req,     // switches to failsafe
  output logic                             fault_output_n,   // fault pin, low active
  output logic                             resistor_decode_pending, // bit 8 copy
  output logic                             config_pending    // bit 9 copy
);

  localparam int CLKCNT_W = $clog2(EXTCLK_MAX_CYC + 2);  // ext period counter width
  localparam int WUNIT_W  = $clog2(WDOG_UNIT_CYC + 1);   // unit prescaler width
  localparam int GAP_W    = $clog2(RX_GAP_BITS + 2);     // gap bit counter width

  // refuse settings the counters cannot hold
  generate
    if (WDOG_UNIT_CYC < 1 || EXTCLK_MAX_CYC < 2 || RX_GAP_BITS < 1) begin : g_bad
      $error("lmsf_status_top: timing parameters out of range");
    end
    if (NUM_SW < 1) begin : g_bad_sw
      $error("lmsf_status_top: NUM_SW must be at least 1");
    end
  endgenerate

  // decoded register writes
  logic                      wr_gen;        // write to general status
  logic                      wr_ser;        // write to serial status
  logic [1:0]                thermal_clr;   // w1c strobes, thermal bits
  logic [`LMSF_SER_FLAGS-1:0] ser_clr;      // w1c strobes, serial bits
  logic [`LMSF_SER_FLAGS-1:0] ser_set;      // serial set events
  logic [`LMSF_SER_FLAGS-1:0] ser_flags;    // serial flags, bits 8..1
  logic [1:0]                thermal_flags; // shutdown, warning

  // local status state
  logic                      otp_crc_err_r;    // sticky checksum mismatch
  logic                      cfg_pend_r;       // configuration running
  logic                      ext_slow_r;       // external clock too slow
  logic                      ext_prev_r;       // last sample of ext clock
  logic [CLKCNT_W-1:0]       ext_cnt_r;        // clocks since last ext edge
  logic                      rx_prev_r;        // last receive sample
  logic                      rx_edge;          // receive transition seen
  logic [WUNIT_W-1:0]        wunit_cnt_r;      // watchdog unit prescaler
  logic [`LMSF_WDOG_SET_W-1:0] wdog_units_r;   // elapsed idle units
  logic                      wdog_fired_r;     // fired once this idle spell
  logic                      wdog_hit;         // watchdog set event
  logic [GAP_W-1:0]          gap_cnt_r;        // idle bit periods in gap
  lmsf_pkg::lmsf_gap_state_t gap_state_r;      // gap watcher state
  logic                      gap_hit;          // timeout set event
  lmsf_pkg::lmsf_word_t      gen_word;         // general status image
  lmsf_pkg::lmsf_word_t      ser_word;         // serial status image
  logic                      open_fault_summary;   // any open flag
  logic                      short_fault_summary;  // any short flag
  logic                      open_fault_unmasked;  // open flag not led-masked
  logic                      short_fault_unmasked; // short flag not led-masked
  logic                      ext_refclk_slow;      // bit 7 value
  logic                      serial_err_any;       // bit 6 value
  logic [8:0]                fault_src;            // per-bit fault terms

  // write decode; a write of 0 touches nothing
  always_comb begin
    wr_gen      = reg_wr_en && (reg_addr == `LMSF_OFS_GEN_STATUS);
    wr_ser      = reg_wr_en && (reg_addr == `LMSF_OFS_SER_STATUS);
    thermal_clr = wr_gen ? reg_wdata[`LMSF_GEN_THERMAL_SHUTDOWN_FLAG:`LMSF_GEN_THERMAL_WARNING_FLAG] : 2'h0;
    ser_clr     = wr_ser ? reg_wdata[`LMSF_SER_WDOG:`LMSF_SER_LSB]
                         : {`LMSF_SER_FLAGS{1'b0}};
  end

  // thermal flags, write 1 to clear
  lmsf_w1c_flags #(
    .WIDTH (2)
  ) u_thermal (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set_ev  ({thermal_shdn_ev, thermal_warn_ev}),
    .clr_req (thermal_clr),
    .flags_r (thermal_flags)
  );

  // serial set events, bit 8 down to 1
  always_comb begin
    ser_set = {wdog_hit,
               gap_hit,
               rx_crc_fail,
               rx_sync_par_err,
               rx_pl_par_err,
               rx_sync_stop_err,
               payload_stopbit_fail,
               payload_startbit_fail};
  end

  // serial flags, write 1 to clear
  lmsf_w1c_flags #(
    .WIDTH (`LMSF_SER_FLAGS)
  ) u_serial (
    .clk     (clk),
    .sys_rst (sys_rst),
    .set_ev  (ser_set),
    .clr_req (ser_clr),
    .flags_r (ser_flags)
  );

  // failed crc drops the frame at once
  always_comb begin
    frame_reject = rx_crc_fail;
  end

  // otp mismatch; a good readback clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_crc_err_r <= 1'b0;
    end else if (otp_check_done) begin
      otp_crc_err_r <= !otp_crc_ok;
    end
  end

  // start wins over done: a back-to-back write is kept
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_pend_r <= 1'b0;
    end else if (cfg_start) begin
      cfg_pend_r <= 1'b1;
    end else if (cfg_done) begin
      cfg_pend_r <= 1'b0;
    end
  end

  // external clock period check in system clocks
  // a stopped clock saturates the counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_prev_r <= 1'b0;
      ext_cnt_r  <= '0;
      ext_slow_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_clock_input;
      if (ext_clock_input && !ext_prev_r) begin
        // rising edge: judge the period just ended
        ext_slow_r <= (ext_cnt_r > CLKCNT_W'(EXTCLK_MAX_CYC));
        ext_cnt_r  <= '0;
      end else if (ext_cnt_r <= CLKCNT_W'(EXTCLK_MAX_CYC)) begin
        ext_cnt_r <= ext_cnt_r + 1'b1;
      end else begin
        // no edge for too long: slow now
        ext_slow_r <= 1'b1;
      end
    end
  end

  // receive line transition detect
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_pin;
    end
  end

  always_comb begin
    rx_edge = rx_pin ^ rx_prev_r;
  end

  // watchdog: fires once per idle spell
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wunit_cnt_r  <= '0;
      wdog_units_r <= '0;
      wdog_fired_r <= 1'b0;
    end else if (rx_edge || idle_timeout_setting == '0) begin
      // activity or off restarts timing
      wunit_cnt_r  <= '0;
      wdog_units_r <= '0;
      wdog_fired_r <= 1'b0;
    end else if (wdog_hit) begin
      wdog_fired_r <= 1'b1;
    end else if (!wdog_fired_r) begin
      if (wunit_cnt_r == WUNIT_W'(WDOG_UNIT_CYC - 1)) begin
        wunit_cnt_r  <= '0;
        wdog_units_r <= wdog_units_r + 1'b1;
      end else begin
        wunit_cnt_r <= wunit_cnt_r + 1'b1;
      end
    end
  end

  // set pulse when the programmed unit count is reached
  always_comb begin
    wdog_hit = !wdog_fired_r && !rx_edge
            && (idle_timeout_setting != '0)
            && (wdog_units_r == idle_timeout_setting);
  end

  // gap watcher: armed after a frame, counts idle bit periods
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_state_r <= lmsf_pkg::GAP_IDLE;
      gap_cnt_r   <= '0;
    end else begin
      case (gap_state_r)
        lmsf_pkg::GAP_IDLE: begin
          // idle until a frame is seen
          gap_cnt_r <= '0;
          if (frame_active) begin
            gap_state_r <= lmsf_pkg::GAP_ARMED;
          end
        end
        lmsf_pkg::GAP_ARMED: begin
          if (frame_active || rx_edge) begin
            gap_cnt_r <= '0;
          end else if (gap_hit) begin
            gap_state_r <= lmsf_pkg::GAP_TRIPPED;
          end else if (bit_tick) begin
            gap_cnt_r <= gap_cnt_r + 1'b1;
          end
        end
        lmsf_pkg::GAP_TRIPPED: begin
          // one report per gap; the next frame re-arms
          gap_cnt_r <= '0;
          if (frame_active) begin
            gap_state_r <= lmsf_pkg::GAP_ARMED;
          end
        end
        default: begin
          gap_state_r <= lmsf_pkg::GAP_IDLE;
          gap_cnt_r   <= '0;
        end
      endcase
    end
  end

  // count above the allowed gap trips it
  always_comb begin
    gap_hit = (gap_state_r == lmsf_pkg::GAP_ARMED) && !frame_active && !rx_edge
           && (gap_cnt_r > GAP_W'(RX_GAP_BITS));
  end

  // gap trip sends switches to failsafe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      failsafe_req <= 1'b0;
    end else begin
      failsafe_req <= gap_hit;
    end
  end

  // status shows raw flags, fault uses led masks
  always_comb begin
    open_fault_summary   = |per_switch_open_flags;
    short_fault_summary  = |per_switch_short_flags;
    open_fault_unmasked  = |(per_switch_open_flags & ~led_fault_mask);
    short_fault_unmasked = |(per_switch_short_flags & ~led_fault_mask);
    ext_refclk_slow      = dim_clk_sel[1] && ext_slow_r;
    serial_err_any       = |ser_flags;
  end

  // general status image, unused bits read zero
  always_comb begin
    gen_word                       = `LMSF_GEN_RESET;
    gen_word[`LMSF_GEN_OTP_CRC]    = otp_crc_err_r;
    gen_word[`LMSF_GEN_CFG_PEND]   = cfg_pend_r;
    gen_word[`LMSF_GEN_RES_DEC]    = !grade_read_done;
    gen_word[`LMSF_GEN_EXT_CLK]    = ext_refclk_slow;
    gen_word[`LMSF_GEN_SER_ERR]    = serial_err_any;
    gen_word[`LMSF_GEN_OPEN]       = open_fault_summary;
    gen_word[`LMSF_GEN_SHORT]      = short_fault_summary;
    gen_word[`LMSF_GEN_PUMP_LOW]   = pump_voltage_low;
    gen_word[`LMSF_GEN_THERMAL_SHUTDOWN_FLAG]    = thermal_flags[1];
    gen_word[`LMSF_GEN_THERMAL_WARNING_FLAG]    = thermal_flags[0];
  end

  // serial image, unused bits read zero
  always_comb begin
    ser_word = `LMSF_SER_RESET;
    ser_word[`LMSF_SER_WDOG:`LMSF_SER_LSB] = ser_flags;
  end

  // fault terms; bits 10 and 9 never fault
  always_comb begin
    fault_src = gen_word[8:0] & 9'(`LMSF_GEN_FAULT_EN);
    fault_src[`LMSF_GEN_OPEN]  = open_fault_unmasked;
    fault_src[`LMSF_GEN_SHORT] = short_fault_unmasked;
  end

  // registered so the pin cannot glitch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_output_n <= 1'b1;
    end else begin
      fault_output_n <= !(|(fault_src & ~gen_fault_mask));
    end
  end

  // status copies
  always_comb begin
    resistor_decode_pending = gen_word[`LMSF_GEN_RES_DEC];
    config_pending          = cfg_pend_r;
  end

  // read port: data one cycle on, unmapped reads zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          `LMSF_OFS_GEN_STATUS: reg_rdata <= gen_word;
          `LMSF_OFS_SER_STATUS: reg_rdata <= ser_word;
          default:              reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule : lmsf_status_top

// ===== test/lmsf_host_model.sv
// host side of the register port; config requests are dropped while the device is busy
module lmsf_host_model (
  input  logic                 clk, // clock
  input  logic                 sys_rst, // reset, high
  input  logic                 cmd_go, // start access
  input  logic                 cmd_wr, // 1 write
  input  logic [7:0]           cmd_addr, // offset
  input  lmsf_pkg::lmsf_word_t cmd_wdata, // data
  input  logic                 cfg_req, // config wanted
  input  logic                 config_pending, // busy
  input  logic                 reg_rvalid, // read answer
  input  lmsf_pkg::lmsf_word_t reg_rdata, // read data
  output logic                 reg_wr_en, // write strobe
  output logic                 reg_rd_en, // read strobe
  output logic [7:0]           reg_addr, // offset
  output lmsf_pkg::lmsf_word_t reg_wdata, // write data
  output logic                 cfg_start, // config issued
  output logic                 done, // access over
  output lmsf_pkg::lmsf_word_t rd_data // read capture
);
  // one-cycle strobes; busy requests are dropped
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      cfg_start <= 1'b0;
      done      <= 1'b0;
    end else begin
      reg_wr_en <= cmd_go & cmd_wr;
      reg_rd_en <= cmd_go & ~cmd_wr;
      cfg_start <= cfg_req & ~config_pending;
      done      <= reg_wr_en | reg_rvalid;
    end
  end

  // idle address and data scramble
  always_ff @(posedge clk) begin
    reg_addr  <= cmd_go ? cmd_addr : ~reg_addr;
    reg_wdata <= cmd_go ? cmd_wdata : ~reg_wdata;
    if (reg_rvalid) begin
      rd_data <= reg_rdata;
    end
  end
endmodule : lmsf_host_model

// ===== test/lmsf_status_top_properties.sv
// port-level checks of the status block
module lmsf_status_props (
  input logic       clk, // clock
  input logic       sys_rst, // reset, high
  input logic       cfg_start, // config taken
  input logic       cfg_done, // config over
  input logic       grade_read_done, // decode done
  input logic       pump_voltage_low, // pump low
  input logic       rx_crc_fail, // crc fail
  input logic       rx_pl_par_err, // parity fail
  input logic [8:0] gen_fault_mask, // fault masks
  input logic       frame_reject, // frame drop
  input logic       failsafe_req, // failsafe
  input logic       fault_output_n, // fault pin
  input logic       resistor_decode_pending, // bit 8
  input logic       config_pending // bit 9
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // pending follows start, holds until done
  AST_CFG_SET: assert property (cfg_start |=> config_pending)
    else $error("pending not set");
  AST_CFG_HOLD: assert property (config_pending && !cfg_done |=> config_pending)
    else $error("pending fell early");
  AST_CFG_CLR: assert property (cfg_done && !cfg_start |=> !config_pending)
    else $error("pending stuck");
  // decode flag is the inverse of completion
  AST_RES_DEC: assert property (resistor_decode_pending == !grade_read_done)
    else $error("decode pending wrong");
  // unmasked faults reach the pin within two edges
  AST_FAULT_RES: assert property (!grade_read_done && !gen_fault_mask[8] |-> ##[1:2] !fault_output_n)
    else $error("decode fault missing");
  AST_PUMP: assert property (pump_voltage_low && !gen_fault_mask[2] |-> ##[1:2] !fault_output_n)
    else $error("pump fault missing");
  AST_SER_FAULT: assert property (rx_pl_par_err && !gen_fault_mask[6] |-> ##[1:2] !fault_output_n)
    else $error("serial fault missing");
  // rejection is immediate with the failed check
  AST_REJECT: assert property (frame_reject == rx_crc_fail)
    else $error("reject mismatch");
  AST_FAILSAFE: assert property (failsafe_req |=> !failsafe_req)
    else $error("failsafe not a pulse");

  C_FAILSAFE: cover property (failsafe_req);
  C_CFG_END: cover property ($fell(config_pending));
  C_FAULT: cover property ($fell(fault_output_n));
endmodule : lmsf_status_props

bind lmsf_status_top lmsf_status_props u_props (
  .clk(clk), .sys_rst(sys_rst), .cfg_start(cfg_start), .cfg_done(cfg_done),
  .grade_read_done(grade_read_done), .pump_voltage_low(pump_voltage_low),
  .rx_crc_fail(rx_crc_fail), .rx_pl_par_err(rx_pl_par_err), .gen_fault_mask(gen_fault_mask),
  .frame_reject(frame_reject), .failsafe_req(failsafe_req), .fault_output_n(fault_output_n),
  .resistor_decode_pending(resistor_decode_pending), .config_pending(config_pending));

// ===== test/lmsf_status_top_tb.sv
module lmsf_status_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 8;  // short watchdog unit
  localparam int XC = 16; // short ext clock limit
  typedef struct packed {logic [7:0] ev; logic [12:0] ser; logic [12:0] gen;} lmsf_row_t;
  logic       clk, cmd_go = 0, cmd_wr = 0, done, cfg_start, reg_wr_en, reg_rd_en, reg_rvalid;
  logic       sys_rst = 1, otp_check_done = 0, otp_crc_ok = 1, cfg_req = 0, cfg_done = 0;
  logic       grade_read_done = 1, pump_voltage_low = 0, ext_run = 0, tick_en = 0;
  logic       ext_clock_input = 0, bit_tick = 0, frame_active = 0, rx_pin = 1;
  logic       failsafe_req, fault_output_n, config_pending;
  logic [1:0] dim_clk_sel = 0;                        // dimming clock select
  logic [3:0] idle_timeout_setting = 0;               // watchdog off
  logic [7:0] ev = 0, cmd_addr = 0, reg_addr;         // event pulses, offsets
  logic [8:0] gen_fault_mask = 0;                     // general masks
  logic [11:0] per_switch_open_flags = 0, per_switch_short_flags = 0, led_fault_mask = 0;
  lmsf_pkg::lmsf_word_t cmd_wdata = 0, rd_data, reg_wdata, reg_rdata;
  int         miscompares = 0, samples_checked = 0, cyc = 0, n;
  // event rows: crc, sync par, pl par, sync stop, pl stop, pl start, shdn, warn
  lmsf_row_t rows [8] = '{'{8'h01, 13'h0040, 13'h0040}, '{8'h02, 13'h0020, 13'h0040},
    '{8'h04, 13'h0010, 13'h0040}, '{8'h08, 13'h0008, 13'h0040}, '{8'h10, 13'h0004, 13'h0040},
    '{8'h20, 13'h0002, 13'h0040}, '{8'h40, 13'h0000, 13'h0002}, '{8'h80, 13'h0000, 13'h0001}};

  lmsf_status_top #(.WDOG_UNIT_CYC(WD), .EXTCLK_MAX_CYC(XC)) u_dut (
    .clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .otp_check_done, .otp_crc_ok, .cfg_start, .cfg_done, .grade_read_done, .dim_clk_sel,
    .ext_clock_input, .per_switch_open_flags, .per_switch_short_flags, .pump_voltage_low,
    .thermal_shdn_ev(ev[6]), .thermal_warn_ev(ev[7]), .gen_fault_mask, .led_fault_mask,
    .rx_pin, .bit_tick, .frame_active, .idle_timeout_setting, .rx_crc_fail(ev[0]),
    .rx_sync_par_err(ev[1]), .rx_pl_par_err(ev[2]), .rx_sync_stop_err(ev[3]),
    .payload_stopbit_fail(ev[4]), .payload_startbit_fail(ev[5]), .frame_reject(), .failsafe_req,
    .fault_output_n, .resistor_decode_pending(), .config_pending);
  lmsf_host_model u_host (.clk, .sys_rst, .cmd_go, .cmd_wr, .cmd_addr, .cmd_wdata, .cfg_req,
    .config_pending, .reg_rvalid, .reg_rdata, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .cfg_start, .done, .rd_data);

  // 25 MHz system clock
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // cycle count, bit ticks, ext clock, hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    bit_tick <= tick_en & (cyc[1:0] == 2'h0);
    ext_clock_input <= ext_run & cyc[2];
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one access through the host model
  task automatic acc(input logic wr, input logic [7:0] a, input logic [12:0] d);
    cmd_wr <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_go <= 1'b1;
    @(posedge clk);
    cmd_go <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
  endtask : acc

  task automatic rdc(input logic [7:0] a, input logic [12:0] exp);
    acc(1'b0, a, 13'h0000);
    chk(rd_data, exp);
  endtask : rdc

  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask : tk

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // reset, event table, awkward cases
  initial begin
    tk(20);
    sys_rst <= 1'b0;
    tk(1);
    rdc(8'h10, 13'h0000);
    rdc(8'h11, 13'h0000);
    rdc(8'h3f, 13'h0000);
    foreach (rows[i]) begin
      ev <= rows[i].ev;
      tk(1);
      ev <= 8'h00;
      tk(3);
      chk(13'(fault_output_n), 13'h0000);
      rdc(8'h11, rows[i].ser);
      rdc(8'h10, rows[i].gen);
      acc(1'b1, 8'h11, 13'h0000);
      acc(1'b1, 8'h10, 13'h0000);
      rdc(8'h10, rows[i].gen);
      acc(1'b1, 8'h11, rows[i].ser);
      acc(1'b1, 8'h10, rows[i].gen & 13'h0003);
      rdc(8'h10, 13'h0000);
      chk(13'(fault_output_n), 13'h0001);
    end
    // a set arriving with its clear wins
    fork
      acc(1'b1, 8'h11, 13'h0040);
      begin
        tk(1);
        ev <= 8'h01;
        tk(1);
        ev <= 8'h00;
      end
    join
    rdc(8'h11, 13'h0040);
    acc(1'b1, 8'h11, 13'h0040);
    otp_crc_ok <= 1'b0;
    otp_check_done <= 1'b1;
    tk(1);
    otp_check_done <= 1'b0;
    rdc(8'h10, 13'h0400);
    chk(13'(fault_output_n), 13'h0001);
    otp_crc_ok <= 1'b1;
    otp_check_done <= 1'b1;
    tk(1);
    otp_check_done <= 1'b0;
    rdc(8'h10, 13'h0000);
    cfg_req <= 1'b1;
    tk(1);
    cfg_req <= 1'b0;
    rdc(8'h10, 13'h0200);
    chk(13'(fault_output_n), 13'h0001);
    cfg_done <= 1'b1;
    tk(1);
    cfg_done <= 1'b0;
    rdc(8'h10, 13'h0000);
    grade_read_done <= 1'b0;
    rdc(8'h10, 13'h0100);
    chk(13'(fault_output_n), 13'h0000);
    gen_fault_mask <= 9'h100;
    tk(3);
    chk(13'(fault_output_n), 13'h0001);
    grade_read_done <= 1'b1;
    gen_fault_mask <= 9'h000;
    dim_clk_sel <= 2'h2;
    tk(2 * XC + 8);
    rdc(8'h10, 13'h0080);
    dim_clk_sel <= 2'h3;
    ext_run <= 1'b1;
    tk(2 * XC + 8);
    rdc(8'h10, 13'h0000);
    ext_run <= 1'b0;
    dim_clk_sel <= 2'h1;
    tk(2 * XC + 8);
    rdc(8'h10, 13'h0000);
    per_switch_open_flags <= 12'h800;
    per_switch_short_flags <= 12'h001;
    pump_voltage_low <= 1'b1;
    rdc(8'h10, 13'h001c);
    led_fault_mask <= 12'h801;
    gen_fault_mask <= 9'h004;
    tk(3);
    chk(13'(fault_output_n), 13'h0001);
    per_switch_open_flags <= 12'h000;
    per_switch_short_flags <= 12'h000;
    pump_voltage_low <= 1'b0;
    gen_fault_mask <= 9'h000;
    rdc(8'h10, 13'h0000);
    idle_timeout_setting <= 4'h2;
    tk(2 * WD + 10);
    idle_timeout_setting <= 4'h0;
    rdc(8'h11, 13'h0100);
    acc(1'b1, 8'h11, 13'h0100);
    rdc(8'h11, 13'h0000);
    frame_active <= 1'b1;
    tk(4);
    frame_active <= 1'b0;
    tick_en <= 1'b1;
    n = 0;
    while (failsafe_req !== 1'b1 && n < 200) begin
      tk(1);
      n++;
    end
    tick_en <= 1'b0;
    chk(13'(n >= 62 && n <= 80), 13'h0001);
    rdc(8'h11, 13'h0080);
    end_of_test();
  end
endmodule : lmsf_status_top_tb
